// ==== design/sss_settle_fsm.sv ====
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sss_cfg.svh"
// ----------------------------------------
// Servo settling state machine with AHB-Lite register slave
// ----------------------------------------
module sss_settle_fsm #(
  parameter int W = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic motionStart,
  input wire logic profileDone,
  input wire logic [W-1:0] posErr,
  input wire logic [W-1:0] velErr,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output sss_pkg::sss_state_t ctrlState,
  output logic settleErr,
  output logic irq
);
  import sss_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] syncA;
  logic [1:0] syncB;
  logic [W-1:0] posA;
  logic [W-1:0] posB;
  logic [W-1:0] velA;
  logic [W-1:0] velB;
  logic startS;
  logic doneS;
  // Control pins come from other logic domains, so two stages each.
  always_ff @(posedge clock) begin
    if (rst) begin
      syncA <= 2'h0;
      syncB <= 2'h0;
      posA <= '0;
      posB <= '0;
      velA <= '0;
      velB <= '0;
    end else if (clkEn) begin
      syncA <= {profileDone, motionStart};
      syncB <= syncA;
      posA <= posErr;
      posB <= posA;
      velA <= velErr;
      velB <= velA;
    end
  end
  assign startS = syncB[0];
  assign doneS = syncB[1];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [W-1:0] posWindow;
  logic [W-1:0] velWindow;
  logic [31:0] dwellTime;
  logic [31:0] steadyDelay;
  logic [31:0] settleTimeout;
  logic [31:0] maxSettleTime;
  logic [`SSS_IRQ_W-1:0] irqStatus;
  logic [`SSS_IRQ_W-1:0] irqMask;
  logic [31:0] lastSettle;
  logic enable;

  // AHB address phase capture.
  logic dpValid;
  logic dpWrite;
  logic [11:0] dpAddr;
  wire addrTaken = hsel && hready && htrans == `SSS_HTRANS_NONSEQ;
  wire wrCtrl = dpValid && dpWrite && dpAddr == `SSS_ADDR_CTRL;
  wire [11:0] rdAddr = haddr[11:0];
  // The read-clear acts in the address phase, where the status is sampled, so an
  // event landing between the sample and the clear cannot be lost.
  wire rdIrq = addrTaken && !hwrite && rdAddr == `SSS_ADDR_IRQ;

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  sss_state_t state;
  sss_state_t next_state;
  logic [31:0] phaseCnt;
  logic [31:0] dwellCnt;
  logic [31:0] settleCnt;
  logic inWin;
  logic errDone;

  sss_window_check #(.W(W)) uWin (
    .posErr(posB),
    .velErr(velB),
    .posWindow(posWindow),
    .velWindow(velWindow),
    .inWindows(inWin)
  );

  wire dwellMet = inWin && (dwellCnt + 32'h1 >= dwellTime);
  wire tmoHit = (phaseCnt + 32'h1 >= settleTimeout);
  wire delayMet = (phaseCnt + 32'h1 >= steadyDelay);
  wire noCriteria = (settleTimeout == 32'h0);
  wire errHit = (state != SSS_AT_REST) && (state != SSS_IN_MOTION)
    && !errDone && maxSettleTime != 32'h0 && settleCnt >= maxSettleTime;

  // Next-state choice; a new motion beats every other condition.
  always_comb begin
    next_state = state;
    if (startS) begin
      next_state = SSS_IN_MOTION;
    end else begin
      case (state)
        SSS_IN_MOTION: begin
          if (doneS) begin
            // Zero timeout bypasses all settling checks.
            next_state = noCriteria ? SSS_AT_REST : SSS_CONVERGING;
          end
        end
        SSS_CONVERGING: begin
          if (dwellMet || tmoHit) begin
            next_state = SSS_HOLDING;
          end
        end
        SSS_HOLDING: begin
          // Leaving a window restarts the delay rather than the whole settle.
          if (inWin && delayMet) begin
            next_state = SSS_AT_REST;
          end
        end
        default: next_state = state;
      endcase
    end
  end

  // Counters: phase time, window dwell, and total settle time.
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= SSS_IN_MOTION;
      phaseCnt <= 32'h0;
      dwellCnt <= 32'h0;
      settleCnt <= 32'h0;
      errDone <= 1'b0;
      lastSettle <= 32'h0;
    end else if (clkEn && enable) begin
      state <= next_state;
      if (next_state != state || (state == SSS_HOLDING && !inWin)) begin
        phaseCnt <= 32'h0;
      end else begin
        phaseCnt <= phaseCnt + 32'h1;
      end
      dwellCnt <= (state == SSS_CONVERGING && inWin) ? dwellCnt + 32'h1 : 32'h0;
      // Settle time runs from generator done until at rest.
      if (state == SSS_IN_MOTION) begin
        settleCnt <= 32'h0;
        errDone <= 1'b0;
      end else if (state != SSS_AT_REST) begin
        settleCnt <= settleCnt + 32'h1;
      end
      if (errHit) begin
        errDone <= 1'b1;
      end
      if (next_state == SSS_AT_REST && state != SSS_AT_REST) begin
        lastSettle <= settleCnt;
      end
    end
  end

  // Events: error, reached rest, forced exit from converging.
  wire [`SSS_IRQ_W-1:0] evt;
  assign evt[`SSS_IRQ_ERR] = clkEn && enable && errHit;
  assign evt[`SSS_IRQ_REST] = clkEn && enable && next_state == SSS_AT_REST
    && state != SSS_AT_REST;
  assign evt[`SSS_IRQ_FORCED] = clkEn && enable && state == SSS_CONVERGING
    && !startS && tmoHit && !dwellMet;

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  logic [31:0] rdMux;
  always_comb begin
    rdMux = `SSS_RESET_WORD;
    if (rdAddr == `SSS_ADDR_CTRL) begin
      rdMux = {31'h0, enable};
    end else if (rdAddr == `SSS_ADDR_POSWIN) begin
      rdMux = 32'(posWindow);
    end else if (rdAddr == `SSS_ADDR_VELWIN) begin
      rdMux = 32'(velWindow);
    end else if (rdAddr == `SSS_ADDR_DWELL) begin
      rdMux = dwellTime;
    end else if (rdAddr == `SSS_ADDR_DELAY) begin
      rdMux = steadyDelay;
    end else if (rdAddr == `SSS_ADDR_TMO) begin
      rdMux = settleTimeout;
    end else if (rdAddr == `SSS_ADDR_MAXST) begin
      rdMux = maxSettleTime;
    end else if (rdAddr == `SSS_ADDR_STATUS) begin
      rdMux = {30'h0, state};
    end else if (rdAddr == `SSS_ADDR_IRQ) begin
      rdMux = {29'h0, irqStatus};
    end else if (rdAddr == `SSS_ADDR_MASK) begin
      rdMux = {29'h0, irqMask};
    end else if (rdAddr == `SSS_ADDR_SETTLED) begin
      rdMux = lastSettle;
    end
  end

  // Address phase latch and read data capture; the slave never stalls.
  always_ff @(posedge clock) begin
    if (rst) begin
      dpValid <= 1'b0;
      dpWrite <= 1'b0;
      dpAddr <= 12'h0;
      hrdata <= `SSS_RESET_WORD;
    end else if (clkEn) begin
      dpValid <= addrTaken;
      dpWrite <= hwrite;
      dpAddr <= haddr[11:0];
      hrdata <= (addrTaken && !hwrite) ? rdMux : hrdata;
    end
  end

  // Writes land in the data phase, the only cycle in which hwdata stands.
  always_ff @(posedge clock) begin
    if (rst) begin
      posWindow <= '0;
      velWindow <= '0;
      dwellTime <= 32'h0;
      steadyDelay <= 32'h0;
      settleTimeout <= 32'h0;
      maxSettleTime <= 32'h0;
      irqMask <= '0;
      enable <= 1'b0;
    end else if (clkEn && dpValid && dpWrite) begin
      if (wrCtrl) begin
        enable <= hwdata[0];
      end else if (dpAddr == `SSS_ADDR_POSWIN) begin
        posWindow <= hwdata[W-1:0];
      end else if (dpAddr == `SSS_ADDR_VELWIN) begin
        velWindow <= hwdata[W-1:0];
      end else if (dpAddr == `SSS_ADDR_DWELL) begin
        dwellTime <= hwdata;
      end else if (dpAddr == `SSS_ADDR_DELAY) begin
        steadyDelay <= hwdata;
      end else if (dpAddr == `SSS_ADDR_TMO) begin
        settleTimeout <= hwdata;
      end else if (dpAddr == `SSS_ADDR_MAXST) begin
        maxSettleTime <= hwdata;
      end else if (dpAddr == `SSS_ADDR_MASK) begin
        irqMask <= hwdata[`SSS_IRQ_W-1:0];
      end
    end
  end
  // Sticky status cleared by read; a coincident event is kept.
  always_ff @(posedge clock) begin
    if (rst) begin
      irqStatus <= '0;
      irq <= 1'b0;
      settleErr <= 1'b0;
      ctrlState <= SSS_IN_MOTION;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clkEn) begin
      irqStatus <= (rdIrq ? '0 : irqStatus) | evt;
      irq <= |(((rdIrq ? '0 : irqStatus) | evt) & irqMask);
      settleErr <= evt[`SSS_IRQ_ERR];
      ctrlState <= enable ? next_state : state; // The output tracks the frozen state too.
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_start_moves;
    @(posedge clock) disable iff (rst) (clkEn && enable && startS) |=> state == SSS_IN_MOTION;
  endproperty
  a_start_moves: assert property (p_start_moves) else $error("start did not force motion");
  property p_hold_needs_win;
    @(posedge clock) disable iff (rst)
      (state == SSS_HOLDING && clkEn && enable && !inWin) |=> state != SSS_AT_REST;
  endproperty
  a_hold_needs_win: assert property (p_hold_needs_win) else $error("rest outside window");
  property p_conv_exit;
    @(posedge clock) disable iff (rst)
      (state == SSS_CONVERGING && $past(state) == SSS_CONVERGING && clkEn && enable && !startS
       && !inWin && !tmoHit) |=> state == SSS_CONVERGING;
  endproperty
  a_conv_exit: assert property (p_conv_exit) else $error("early converge exit");
  property p_tmo;
    @(posedge clock) disable iff (rst)
      (state == SSS_CONVERGING && clkEn && enable && !startS && tmoHit) |=> state == SSS_HOLDING;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout ignored");
  property p_silent;
    @(posedge clock) disable iff (rst) evt[`SSS_IRQ_FORCED] && !errHit |=> !settleErr;
  endproperty
  a_silent: assert property (p_silent) else $error("timeout raised error");
  property p_zero;
    @(posedge clock) disable iff (rst)
      (state == SSS_IN_MOTION && clkEn && enable && doneS && !startS && noCriteria)
      |=> state == SSS_AT_REST;
  endproperty
  a_zero: assert property (p_zero) else $error("zero timeout not bypassed");
  property p_done;
    @(posedge clock) disable iff (rst)
      (state == SSS_IN_MOTION && clkEn && enable && doneS && !startS && !noCriteria)
      |=> state == SSS_CONVERGING;
  endproperty
  a_done: assert property (p_done) else $error("profile done ignored");
  property p_delay;
    @(posedge clock) disable iff (rst)
      (state == SSS_HOLDING && $past(state) == SSS_HOLDING && clkEn && enable && !startS
       && inWin && !delayMet) |=> state == SSS_HOLDING;
  endproperty
  a_delay: assert property (p_delay) else $error("steady delay cut short");
  property p_err;
    @(posedge clock) disable iff (rst) evt[`SSS_IRQ_ERR] |=> settleErr ##1 !settleErr;
  endproperty
  a_err: assert property (p_err) else $error("error pulse wrong");
  property p_time;
    @(posedge clock) disable iff (rst)
      (state == SSS_IN_MOTION && clkEn && enable) |=> settleCnt == 32'h0;
  endproperty
  a_time: assert property (p_time) else $error("settle time not restarted");
  property p_forced;
    @(posedge clock) disable iff (rst) (state == SSS_CONVERGING && clkEn && enable && !startS
      && tmoHit && !dwellMet) |=> irqStatus[`SSS_IRQ_FORCED];
  endproperty
  a_forced: assert property (p_forced) else $error("forced exit not recorded");
  c_zero: cover property (@(posedge clock) state == SSS_IN_MOTION ##1 state == SSS_AT_REST);
  c_abort: cover property (@(posedge clock) state == SSS_CONVERGING ##1 state == SSS_IN_MOTION);
  c_rest: cover property (@(posedge clock) state == SSS_HOLDING ##1 state == SSS_AT_REST);
  c_forced: cover property (@(posedge clock) evt[`SSS_IRQ_FORCED]);
  c_err: cover property (@(posedge clock) settleErr);
endmodule
`default_nettype wire

// ==== design/sss_cfg.svh ====
// Function
// - Converge to holding after windows held dwell.
// - Holding waits steady delay, then at rest.
// - New motion forces in-motion from anywhere.
// - Steady delay requires windows held throughout.
// - Converging time bounded by timeout, forced exit.
// - Timeout exit raises no error.
// - Zero timeout skips criteria, goes at rest.
// - Timeout timed from generator ready onward.
// - Settling longer than maximum flags error event.
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH
`define SSS_ADDR_CTRL 12'h000
`define SSS_ADDR_POSWIN 12'h004
`define SSS_ADDR_VELWIN 12'h008
`define SSS_ADDR_DWELL 12'h00c
`define SSS_ADDR_DELAY 12'h010
`define SSS_ADDR_TMO 12'h014
`define SSS_ADDR_MAXST 12'h018
`define SSS_ADDR_STATUS 12'h01c
`define SSS_ADDR_IRQ 12'h020
`define SSS_ADDR_MASK 12'h024
`define SSS_ADDR_SETTLED 12'h028
`define SSS_IRQ_ERR 0
`define SSS_IRQ_REST 1
`define SSS_IRQ_FORCED 2
`define SSS_IRQ_W 3
`define SSS_RESET_WORD 32'h0000_0000
`define SSS_HTRANS_NONSEQ 2'b10
`endif

// ==== design/sss_pkg.sv ====
package sss_pkg;
  typedef enum logic [1:0] {
    SSS_IN_MOTION = 2'b00,
    SSS_CONVERGING = 2'b01,
    SSS_HOLDING = 2'b11,
    SSS_AT_REST = 2'b10
  } sss_state_t;
endpackage

// ==== design/sss_window_check.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Window comparison for position and velocity errors
// ----------------------------------------
module sss_window_check #(
  parameter int W = 32
) (
  input wire logic [W-1:0] posErr,
  input wire logic [W-1:0] velErr,
  input wire logic [W-1:0] posWindow,
  input wire logic [W-1:0] velWindow,
  output logic inWindows
);
  logic [W-1:0] posMag;
  logic [W-1:0] velMag;
  // Signed errors are folded to magnitudes so one window serves both signs.
  assign posMag = posErr[W-1] ? W'(-posErr) : posErr;
  assign velMag = velErr[W-1] ? W'(-velErr) : velErr;
  assign inWindows = (posMag <= posWindow) && (velMag <= velWindow);
endmodule
`default_nettype wire

// ==== verification/sss_axis_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Setpoint generator and axis feedback model
// ----------------------------------------
module sss_axis_model (
  input wire logic clock,
  input wire logic go,
  input wire logic near,
  output logic motionStart = 1'b1,
  output logic profileDone = 1'b0,
  output logic [31:0] posErr = 32'h0000_0000,
  output logic [31:0] velErr = 32'h0000_0000
);
  logic [7:0] jitter = 8'h00;

  // Outputs change just after the edge; off-window errors wander every cycle so
  // that a design holding a stale sample cannot look settled by luck.
  always @(posedge clock) begin
    jitter <= jitter + 8'h01;
    motionStart <= go;
    profileDone <= !go;
    posErr <= near ? 32'h0000_0003 : 32'h0000_0400 + {24'h00_0000, jitter};
    velErr <= near ? 32'hffff_fffe : 32'hffff_fc00 - {24'h00_0000, jitter};
  end
endmodule
`default_nettype wire

// ==== verification/sss_settle_fsm_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sss_cfg.svh"
module sss_settle_fsm_bench;
  import sss_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b1;
  logic near = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic motionStart, profileDone, hreadyout, hresp, settleErr, irq;
  logic [31:0] posErr, velErr, hrdata, rd;
  sss_state_t ctrlState;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int errPulses = 0;

  sss_axis_model sss_axis_model_i (.clock(clock), .go(go), .near(near),
    .motionStart(motionStart), .profileDone(profileDone), .posErr(posErr), .velErr(velErr));

  sss_settle_fsm sss_settle_fsm_i (.clock(clock), .rst(rst), .clkEn(1'b1),
    .motionStart(motionStart), .profileDone(profileDone), .posErr(posErr), .velErr(velErr),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ctrlState(ctrlState), .settleErr(settleErr), .irq(irq));

  // ----------------------------------------
  // Clock, hang guard and error pulse counter
  // ----------------------------------------
  initial begin
    forever #50 clock = ~clock;
  end

  // The ceiling is tens of times the expected run, so only a hang reaches it.
  always @(posedge clock) begin
    cycles++;
    if (settleErr === 1'b1) errPulses++;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single-word transfer; read data is taken at the data-phase edge.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= `SSS_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {20'h0_0000, a};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
    check("hresp", {31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic wait_state(input sss_state_t st, input int limit);
    int k;
    k = 0;
    while (ctrlState !== st && k < limit) begin
      @(posedge clock);
      k++;
    end
    check("ctrlState", {30'h0, ctrlState}, {30'h0, st});
  endtask

  // Windows of 16, dwell 20 and steady delay 12 are valid whenever a timeout is set.
  task automatic setup(input logic [31:0] tmo, input logic [31:0] maxst);
    bus(1'b1, `SSS_ADDR_POSWIN, 32'h0000_0010);
    bus(1'b1, `SSS_ADDR_VELWIN, 32'h0000_0010);
    bus(1'b1, `SSS_ADDR_DWELL, 32'h0000_0014);
    bus(1'b1, `SSS_ADDR_DELAY, 32'h0000_000c);
    bus(1'b1, `SSS_ADDR_TMO, tmo);
    bus(1'b1, `SSS_ADDR_MAXST, maxst);
    bus(1'b1, `SSS_ADDR_CTRL, 32'h0000_0001);
  endtask

  // Starts a motion, clears stale events, then reports the profile done.
  task automatic move(input logic settles);
    go <= 1'b1;
    bus(1'b0, `SSS_ADDR_IRQ, 32'h0000_0000);
    repeat (6) @(posedge clock);
    near <= settles;
    go <= 1'b0;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdchk("ctrl", `SSS_ADDR_CTRL, `SSS_RESET_WORD);
    rdchk("mask", `SSS_ADDR_MASK, `SSS_RESET_WORD);
    bus(1'b1, 12'h07c, 32'h1234_5678);
    rdchk("unmapped", 12'h07c, 32'h0000_0000);
    bus(1'b1, `SSS_ADDR_MASK, 32'h0000_0007);
    setup(32'h0000_00c8, 32'h0000_0096);
    rdchk("dwell", `SSS_ADDR_DWELL, 32'h0000_0014);
    // A settling axis converges only after the dwell, then holds for the delay.
    move(1'b1);
    wait_state(SSS_CONVERGING, 10);
    repeat (12) @(posedge clock);
    check("ctrlState", {30'h0, ctrlState}, {30'h0, SSS_CONVERGING});
    wait_state(SSS_HOLDING, 20);
    repeat (6) @(posedge clock);
    check("ctrlState", {30'h0, ctrlState}, {30'h0, SSS_HOLDING});
    wait_state(SSS_AT_REST, 15);
    check("irq", {31'h0, irq}, 32'h0000_0001);
    rdchk("irqStatus", `SSS_ADDR_IRQ, 32'h0000_0002);
    check("irq", {31'h0, irq}, 32'h0000_0000);
    rdchk("status", `SSS_ADDR_STATUS, {30'h0, SSS_AT_REST});
    // Leaving the windows while holding keeps the axis from being declared steady.
    move(1'b1);
    wait_state(SSS_HOLDING, 40);
    near <= 1'b0;
    repeat (20) @(posedge clock);
    check("ctrlState", {30'h0, ctrlState}, {30'h0, SSS_HOLDING});
    near <= 1'b1;
    wait_state(SSS_AT_REST, 25);
    go <= 1'b1;
    wait_state(SSS_IN_MOTION, 6);
    // A new motion during convergence aborts it.
    move(1'b0);
    wait_state(SSS_CONVERGING, 10);
    go <= 1'b1;
    wait_state(SSS_IN_MOTION, 6);
    // An axis that never settles is pushed on by the timeout, without an error.
    setup(32'h0000_003c, 32'h0000_012c);
    errPulses = 0;
    move(1'b0);
    wait_state(SSS_CONVERGING, 10);
    repeat (40) @(posedge clock);
    check("ctrlState", {30'h0, ctrlState}, {30'h0, SSS_CONVERGING});
    wait_state(SSS_HOLDING, 30);
    rdchk("irqStatus", `SSS_ADDR_IRQ, 32'h0000_0004);
    check("errPulses", errPulses, 32'h0000_0000);
    near <= 1'b1;
    wait_state(SSS_AT_REST, 30);
    // A slow settle beyond the maximum gives one error event, masked and cleared.
    setup(32'h0000_00c8, 32'h0000_001e);
    move(1'b0);
    errPulses = 0;
    repeat (20) @(posedge clock);
    check("errPulses", errPulses, 32'h0000_0000);
    repeat (30) @(posedge clock);
    check("errPulses", errPulses, 32'h0000_0001);
    check("irq", {31'h0, irq}, 32'h0000_0001);
    bus(1'b1, `SSS_ADDR_MASK, 32'h0000_0006);
    // The mask lands at the data-phase edge; the interrupt flop follows one edge later.
    repeat (2) @(posedge clock);
    check("irq", {31'h0, irq}, 32'h0000_0000);
    bus(1'b1, `SSS_ADDR_MASK, 32'h0000_0007);
    rdchk("irqStatus", `SSS_ADDR_IRQ, 32'h0000_0001);
    near <= 1'b1;
    wait_state(SSS_AT_REST, 60);
    // A zero timeout skips the criteria even for an axis far off target.
    setup(32'h0000_0000, 32'h0000_0000);
    move(1'b0);
    wait_state(SSS_AT_REST, 10);
    print_verdict();
  end
endmodule
`default_nettype wire
